// ===== blsb_map.svh
`ifndef BLSB_MAP_SVH
`define BLSB_MAP_SVH

// ----------------------------------------
// datapath geometry
// ----------------------------------------
`define BLSB_MSB      7
`define BLSB_LSB      0
`define BLSB_IDX_MSB  2

// ----------------------------------------
// reset and constant values
// ----------------------------------------
`define BLSB_BYTE_ZERO 8'h00
`define BLSB_BIT_ONE   8'h01
`define BLSB_IDX_ZERO  3'h0

// ----------------------------------------
// one-hot state codes
// ----------------------------------------
`define BLSB_ST_IDLE    4'h1
`define BLSB_ST_RD_WAIT 4'h2
`define BLSB_ST_EXEC    4'h4
`define BLSB_ST_WR_WAIT 4'h8

`endif

// ===== blsb_pkg.sv
package blsb_pkg;
  `include "blsb_map.svh"

  typedef logic [`BLSB_MSB:`BLSB_LSB] blsb_byte_t;
  typedef logic [`BLSB_IDX_MSB:0] blsb_idx_t;

  typedef enum logic [4:0] {
    op_and, op_or, op_xor, op_not,
    arith_shift_left, arith_shift_right,
    logic_shift_left, logic_shift_right,
    rotate_left, rotate_right,
    rotate_left_via_carry, rotate_right_via_carry,
    bit_set_op, bit_clear_op, bit_invert_op, bit_test_op,
    bit_and_carry_op, inv_bit_and_carry_op,
    bit_or_carry_op, inv_bit_or_carry_op,
    bit_xor_carry_op, inv_bit_xor_carry_op,
    bit_load_carry_op, inv_bit_load_carry_op,
    bit_store_carry_op, inv_bit_store_carry_op
  } blsb_op_t;

  typedef enum logic [3:0] {
    st_idle    = `BLSB_ST_IDLE,
    st_rd_wait = `BLSB_ST_RD_WAIT,
    st_exec    = `BLSB_ST_EXEC,
    st_wr_wait = `BLSB_ST_WR_WAIT
  } blsb_state_t;
endpackage

// ===== blsb_bit_unit.sv
`timescale 1ns/1ps
`include "blsb_map.svh"

module blsb_bit_unit (
  input  blsb_pkg::blsb_op_t   op,        // bit operation
  input  blsb_pkg::blsb_byte_t byte_in,   // operand byte
  input  blsb_pkg::blsb_idx_t  idx,       // selected bit
  input  logic                 carry_in,  // current carry
  output blsb_pkg::blsb_byte_t byte_out,  // modified byte
  output logic                 carry_new, // new carry
  output logic                 zero_new   // new zero
);
  import blsb_pkg::*;

  blsb_byte_t mask;
  blsb_byte_t set_byte;
  blsb_byte_t clr_byte;
  logic       sel;

  assign mask     = `BLSB_BIT_ONE << idx;
  assign sel      = byte_in[idx];
  assign set_byte = byte_in | mask;
  assign clr_byte = byte_in & ~mask;
  assign zero_new = ~sel;

  assign byte_out =
    (op == bit_set_op)             ? set_byte :
    (op == bit_clear_op)           ? clr_byte :
    (op == bit_invert_op)          ? byte_in ^ mask :
    (op == bit_store_carry_op)     ? (carry_in ? set_byte : clr_byte) :
    (op == inv_bit_store_carry_op) ? (carry_in ? clr_byte : set_byte) :
    byte_in;

  assign carry_new =
    (op == bit_and_carry_op)      ? carry_in & sel :
    (op == inv_bit_and_carry_op)  ? carry_in & ~sel :
    (op == bit_or_carry_op)       ? carry_in | sel :
    (op == inv_bit_or_carry_op)   ? carry_in | ~sel :
    (op == bit_xor_carry_op)      ? carry_in ^ sel :
    (op == inv_bit_xor_carry_op)  ? carry_in ^ ~sel :
    (op == bit_load_carry_op)     ? sel :
    (op == inv_bit_load_carry_op) ? ~sel :
    carry_in;
endmodule // blsb_bit_unit

// ===== blsb_top.sv
`timescale 1ns/1ps
`include "blsb_map.svh"

// Notes on behaviour
// - and: dest and src/imm into dest
// - or: dest or src/imm into dest
// - xor: dest xor src/imm into dest
// - not: invert every bit of dest
// - arithmetic shifts move dest one place
// - logical shifts move dest one place
// - carry rotates act as ninth bit
// - set/clear/invert/test index: imm or register
// - inverted carry ops take immediate index
// - set forces selected bit to one
// - clear forces selected bit to zero
// - invert toggles only selected bit
// - test loads zero with inverted bit
// - carry and bit, or inverted bit
// - carry or bit, or inverted bit
// - carry xor bit, or inverted bit
// - load bit or inverse into carry
// - store carry or inverse into bit
module blsb_top (
  input  wire logic                 clk,           // core clock
  input  wire logic                 rst,           // async reset
  input  wire logic                 op_valid,      // request strobe
  input  blsb_pkg::blsb_op_t        op_code,       // operation
  input  blsb_pkg::blsb_byte_t      dest_val,      // destination register
  input  blsb_pkg::blsb_byte_t      source_register, // second register
  input  blsb_pkg::blsb_byte_t      imm_val,       // immediate byte
  input  wire logic                 use_imm,       // take immediate
  input  blsb_pkg::blsb_idx_t       bit_idx_imm,   // immediate index
  input  wire logic                 idx_from_reg,  // index from register
  input  wire logic                 carry_in,      // carry flag
  input  wire logic                 mem_operand,   // operand in memory
  input  blsb_pkg::blsb_byte_t      mem_rd_data,   // memory read byte
  input  wire logic                 mem_rd_valid,  // read answer
  input  wire logic                 mem_wr_ack,    // write answer
  output logic                      busy,          // not idle
  output logic                      done,          // operation finished
  output logic                      reg_wr_en,     // register write strobe
  output blsb_pkg::blsb_byte_t      reg_wr_data,   // register write byte
  output logic                      carry_we,      // carry write strobe
  output logic                      carry_out,     // new carry
  output logic                      zero_we,       // zero write strobe
  output logic                      zero_out,      // new zero
  output logic                      mem_rd_req,    // memory read request
  output logic                      mem_wr_req,    // memory write request
  output blsb_pkg::blsb_byte_t      mem_wr_data    // memory write byte
);
  import blsb_pkg::*;

  // ----------------------------------------
  // operation classes
  // ----------------------------------------
  function automatic logic f_is_bit(input blsb_op_t op);
    f_is_bit = (op >= bit_set_op);
  endfunction

  function automatic logic f_idx_any(input blsb_op_t op);
    f_idx_any = (op >= bit_set_op) && (op <= bit_test_op);
  endfunction

  function automatic logic f_wr_byte(input blsb_op_t op);
    f_wr_byte = !f_is_bit(op) || (op == bit_set_op) ||
                (op == bit_clear_op) || (op == bit_invert_op) ||
                (op == bit_store_carry_op) || (op == inv_bit_store_carry_op);
  endfunction

  function automatic logic f_wr_carry(input blsb_op_t op);
    f_wr_carry = ((op >= arith_shift_left) && (op <= rotate_right_via_carry)) ||
                 ((op >= bit_and_carry_op) && (op <= inv_bit_load_carry_op));
  endfunction

  // ----------------------------------------
  // state and operand registers
  // ----------------------------------------
  blsb_state_t state_reg;
  blsb_state_t state_next;
  blsb_op_t    op_reg;
  blsb_byte_t  a_reg;
  blsb_byte_t  a_next;
  blsb_byte_t  b_reg;
  blsb_idx_t   idx_reg;
  logic        carry_reg;
  logic        mem_reg;

  logic        busy_reg, done_reg, reg_wr_en_reg, carry_we_reg;
  logic        carry_out_reg, zero_we_reg, zero_out_reg;
  logic        mem_rd_req_reg, mem_wr_req_reg;
  blsb_byte_t  reg_wr_data_reg, mem_wr_data_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire        accept     = (state_reg == st_idle) && op_valid;
  wire        mem_path   = mem_operand && f_is_bit(op_code);
  wire        rd_take    = (state_reg == st_rd_wait) && mem_rd_valid;
  wire        exec_fin   = (state_reg == st_exec);
  wire        exec_mem_w = exec_fin && mem_reg && f_wr_byte(op_reg);
  wire        wr_take    = (state_reg == st_wr_wait) && mem_wr_ack;
  wire        idx_sel_r  = idx_from_reg && f_idx_any(op_code);
  wire [2:0]  idx_in     = idx_sel_r ? source_register[`BLSB_IDX_MSB:0]
                                     : bit_idx_imm;

  assign a_next = accept  ? dest_val :
                  rd_take ? mem_rd_data :
                  a_reg;

  // ----------------------------------------
  // logic and shift datapath
  // ----------------------------------------
  wire [6:0] lo7 = a_reg[`BLSB_MSB-1:`BLSB_LSB];
  wire [6:0] hi7 = a_reg[`BLSB_MSB:`BLSB_LSB+1];
  wire       msb = a_reg[`BLSB_MSB];
  wire       lsb = a_reg[`BLSB_LSB];

  blsb_byte_t alu_byte;
  logic       alu_carry;

  always_comb begin
    alu_byte  = a_reg;
    alu_carry = carry_reg;
    case (op_reg)
      op_and:                 alu_byte = a_reg & b_reg;
      op_or:                  alu_byte = a_reg | b_reg;
      op_xor:                 alu_byte = a_reg ^ b_reg;
      op_not:                 alu_byte = ~a_reg;
      arith_shift_left,
      logic_shift_left: begin
        alu_byte  = {lo7, 1'b0};
        alu_carry = msb;
      end
      arith_shift_right: begin
        alu_byte  = {msb, hi7};
        alu_carry = lsb;
      end
      logic_shift_right: begin
        alu_byte  = {1'b0, hi7};
        alu_carry = lsb;
      end
      rotate_left: begin
        alu_byte  = {lo7, msb};
        alu_carry = msb;
      end
      rotate_right: begin
        alu_byte  = {lsb, hi7};
        alu_carry = lsb;
      end
      rotate_left_via_carry: begin
        alu_byte  = {lo7, carry_reg};
        alu_carry = msb;
      end
      rotate_right_via_carry: begin
        alu_byte  = {carry_reg, hi7};
        alu_carry = lsb;
      end
      default: begin
        alu_byte  = a_reg;
        alu_carry = carry_reg;
      end
    endcase
  end

  // ----------------------------------------
  // single-bit datapath
  // ----------------------------------------
  blsb_byte_t bit_byte;
  logic       bit_carry;
  logic       bit_zero;

  blsb_bit_unit u_bit (
    .op        (op_reg),
    .byte_in   (a_reg),
    .idx       (idx_reg),
    .carry_in  (carry_reg),
    .byte_out  (bit_byte),
    .carry_new (bit_carry),
    .zero_new  (bit_zero)
  );

  wire        is_bit    = f_is_bit(op_reg);
  wire [7:0]  res_byte  = is_bit ? bit_byte : alu_byte;
  wire        res_carry = is_bit ? bit_carry : alu_carry;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    case (state_reg)
      st_idle:    state_next = accept ? (mem_path ? st_rd_wait : st_exec) : st_idle;
      st_rd_wait: state_next = mem_rd_valid ? st_exec : st_rd_wait;
      st_exec:    state_next = exec_mem_w ? st_wr_wait : st_idle;
      st_wr_wait: state_next = mem_wr_ack ? st_idle : st_wr_wait;
      default:    state_next = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= st_idle;
      a_reg     <= `BLSB_BYTE_ZERO;
    end else begin
      state_reg <= state_next;
      a_reg     <= a_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_reg    <= op_and;
      b_reg     <= `BLSB_BYTE_ZERO;
      idx_reg   <= `BLSB_IDX_ZERO;
      carry_reg <= 1'b0;
      mem_reg   <= 1'b0;
    end else if (accept) begin
      op_reg    <= op_code;
      b_reg     <= use_imm ? imm_val : source_register;
      idx_reg   <= idx_in;
      carry_reg <= carry_in;
      mem_reg   <= mem_path;
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg       <= 1'b0;
      done_reg       <= 1'b0;
      reg_wr_en_reg  <= 1'b0;
      carry_we_reg   <= 1'b0;
      zero_we_reg    <= 1'b0;
      mem_rd_req_reg <= 1'b0;
      mem_wr_req_reg <= 1'b0;
    end else begin
      busy_reg       <= state_next != st_idle;
      done_reg       <= (exec_fin && !exec_mem_w) || wr_take;
      reg_wr_en_reg  <= exec_fin && !mem_reg && f_wr_byte(op_reg);
      carry_we_reg   <= exec_fin && f_wr_carry(op_reg);
      zero_we_reg    <= exec_fin && (op_reg == bit_test_op);
      mem_rd_req_reg <= state_next == st_rd_wait;
      mem_wr_req_reg <= state_next == st_wr_wait;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr_data_reg <= `BLSB_BYTE_ZERO;
      mem_wr_data_reg <= `BLSB_BYTE_ZERO;
      carry_out_reg   <= 1'b0;
      zero_out_reg    <= 1'b0;
    end else if (exec_fin) begin
      reg_wr_data_reg <= res_byte;
      mem_wr_data_reg <= res_byte;
      carry_out_reg   <= res_carry;
      zero_out_reg    <= bit_zero;
    end
  end

  assign busy        = busy_reg;
  assign done        = done_reg;
  assign reg_wr_en   = reg_wr_en_reg;
  assign reg_wr_data = reg_wr_data_reg;
  assign carry_we    = carry_we_reg;
  assign carry_out   = carry_out_reg;
  assign zero_we     = zero_we_reg;
  assign zero_out    = zero_out_reg;
  assign mem_rd_req  = mem_rd_req_reg;
  assign mem_wr_req  = mem_wr_req_reg;
  assign mem_wr_data = mem_wr_data_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire       sel_bit = a_reg[idx_reg];
  wire [7:0] sel_msk = `BLSB_BIT_ONE << idx_reg;

  and_result_a: assert property (reg_wr_en && op_reg == op_and |->
    reg_wr_data == (a_reg & b_reg)) else $error("and result wrong");
  or_result_a: assert property (reg_wr_en && op_reg == op_or |->
    reg_wr_data == (a_reg | b_reg)) else $error("or result wrong");
  xor_result_a: assert property (reg_wr_en && op_reg == op_xor |->
    reg_wr_data == (a_reg ^ b_reg)) else $error("xor result wrong");
  not_result_a: assert property (reg_wr_en && op_reg == op_not |->
    reg_wr_data == ~a_reg) else $error("complement wrong");
  arith_shift_a: assert property (reg_wr_en && op_reg == arith_shift_right |->
    reg_wr_data == {msb, hi7} && carry_we && carry_out == lsb)
    else $error("arithmetic shift wrong");
  logic_shift_a: assert property (reg_wr_en && op_reg == logic_shift_right |->
    reg_wr_data == {1'b0, hi7}) else $error("logical shift wrong");
  rot_carry_a: assert property (reg_wr_en && op_reg == rotate_left_via_carry |->
    reg_wr_data == {lo7, carry_reg} && carry_out == msb)
    else $error("carry rotate wrong");
  plain_rotate_a: assert property (reg_wr_en && op_reg == rotate_right |->
    reg_wr_data == {lsb, hi7}) else $error("rotate wrong");
  idx_source_a: assert property (accept && idx_from_reg && op_code == bit_set_op |=>
    idx_reg == $past(source_register[`BLSB_IDX_MSB:0])) else $error("register index lost");
  idx_imm_a: assert property (accept && op_code == inv_bit_or_carry_op |=>
    idx_reg == $past(bit_idx_imm)) else $error("inverted op index not immediate");
  bit_set_a: assert property (reg_wr_en && op_reg == bit_set_op |->
    reg_wr_data == (a_reg | sel_msk)) else $error("bit set wrong");
  bit_clear_a: assert property (reg_wr_en && op_reg == bit_clear_op |->
    reg_wr_data == (a_reg & ~sel_msk)) else $error("bit clear wrong");
  bit_invert_a: assert property (reg_wr_en && op_reg == bit_invert_op |->
    reg_wr_data == (a_reg ^ sel_msk)) else $error("bit invert wrong");
  bit_test_a: assert property (done && op_reg == bit_test_op |->
    zero_we && zero_out == !sel_bit && !reg_wr_en && !mem_wr_req)
    else $error("bit test wrong");
  carry_and_a: assert property (carry_we && op_reg == inv_bit_and_carry_op |->
    carry_out == (carry_reg & !sel_bit)) else $error("carry and wrong");
  carry_or_a: assert property (carry_we && op_reg == bit_or_carry_op |->
    carry_out == (carry_reg | sel_bit)) else $error("carry or wrong");
  carry_xor_a: assert property (carry_we && op_reg == inv_bit_xor_carry_op |->
    carry_out == (carry_reg ^ !sel_bit)) else $error("carry xor wrong");
  carry_load_a: assert property (carry_we && op_reg == inv_bit_load_carry_op |->
    carry_out == !sel_bit) else $error("carry load wrong");
  carry_store_a: assert property (reg_wr_en && op_reg == bit_store_carry_op |->
    reg_wr_data[idx_reg] == carry_reg && ((reg_wr_data ^ a_reg) & ~sel_msk) == 8'h00)
    else $error("carry store wrong");
  mem_rmw_a: assert property ($rose(mem_wr_req) |->
    $past(mem_rd_req, 2) && $past(mem_rd_valid, 2) &&
    ((mem_wr_data ^ a_reg) & ~sel_msk) == 8'h00) else $error("memory write not read-modify");
  mem_finish_a: assert property (mem_wr_req && mem_wr_ack |=>
    done && !busy && !mem_wr_req) else $error("memory write did not finish");
  shift_left_a: assert property (reg_wr_en && op_reg == logic_shift_left |->
    reg_wr_data == {lo7, 1'b0} && carry_out == msb) else $error("left shift wrong");
  rotate_left_a: assert property (reg_wr_en && op_reg == rotate_left |->
    reg_wr_data == {lo7, msb} && carry_out == msb) else $error("left rotate wrong");
  carry_and_pos_a: assert property (carry_we && op_reg == bit_and_carry_op |->
    carry_out == (carry_reg & sel_bit)) else $error("carry and plain wrong");
  inv_store_a: assert property ($rose(mem_wr_req) &&
    op_reg == inv_bit_store_carry_op |-> mem_wr_data[idx_reg] == !carry_reg)
    else $error("inverted store wrong");

  reg_op_c: cover property (accept && !mem_path ##2 done && reg_wr_en);
  mem_rmw_c: cover property (mem_rd_req && mem_rd_valid ##[1:8] mem_wr_req && mem_wr_ack);
  mem_test_c: cover property (done && zero_we && mem_reg);
  rot_carry_c: cover property (done && carry_we && op_reg == rotate_right_via_carry);
endmodule // blsb_top

// ===== blsb_tb_top.sv
`timescale 1ns/1ps
module blsb_tb_top;
  import blsb_pkg::*;
  typedef struct packed {
    logic       we;
    blsb_byte_t d;
    logic       cwe;
    logic       c;
    logic       zwe;
    logic       z;
  } blsb_exp_t;
  logic       clk, rst, op_valid, use_imm, idx_from_reg, carry_in;
  logic       mem_operand, mem_rd_valid, mem_wr_ack;
  logic       busy, done, reg_wr_en, carry_we, carry_out, zero_we, zero_out;
  logic       mem_rd_req, mem_wr_req;
  blsb_op_t   op_code;
  blsb_byte_t dest_val, source_register, imm_val, mem_rd_data;
  blsb_byte_t reg_wr_data, mem_wr_data;
  blsb_idx_t  bit_idx_imm;
  blsb_exp_t  exp_q[$];
  blsb_exp_t  mon_e;
  int         mismatches, num_checks, seed;

  blsb_top dut_u (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .dest_val(dest_val), .source_register(source_register), .imm_val(imm_val),
    .use_imm(use_imm), .bit_idx_imm(bit_idx_imm), .idx_from_reg(idx_from_reg),
    .carry_in(carry_in), .mem_operand(mem_operand), .mem_rd_data(mem_rd_data),
    .mem_rd_valid(mem_rd_valid), .mem_wr_ack(mem_wr_ack), .busy(busy), .done(done),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .carry_we(carry_we),
    .carry_out(carry_out), .zero_we(zero_we), .zero_out(zero_out),
    .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req), .mem_wr_data(mem_wr_data));

  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  always #5 clk = ~clk;

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // expected results
  // ----------------------------------------
  function automatic blsb_exp_t model(input blsb_op_t op, input blsb_byte_t a, b,
                                      input blsb_idx_t k, input logic c);
    blsb_exp_t  e;
    blsb_byte_t m;
    logic       t;
    e = '0;
    m = 8'h01 << k;
    t = a[k];
    e.we = op <= bit_invert_op || op >= bit_store_carry_op;
    e.cwe = (op >= arith_shift_left && op <= rotate_right_via_carry) ||
            (op >= bit_and_carry_op && op <= inv_bit_load_carry_op);
    e.zwe = op == bit_test_op;
    e.z = ~t;
    case (op)
      op_and: e.d = a & b;
      op_or: e.d = a | b;
      op_xor: e.d = a ^ b;
      op_not: e.d = ~a;
      arith_shift_left, logic_shift_left: {e.c, e.d} = {a, 1'b0};
      arith_shift_right: {e.d, e.c} = {a[7], a};
      logic_shift_right: {e.d, e.c} = {1'b0, a};
      rotate_left: {e.c, e.d} = {a, a[7]};
      rotate_right: {e.d, e.c} = {a[0], a};
      rotate_left_via_carry: {e.c, e.d} = {a, c};
      rotate_right_via_carry: {e.d, e.c} = {c, a};
      bit_set_op: e.d = a | m;
      bit_clear_op: e.d = a & ~m;
      bit_invert_op: e.d = a ^ m;
      bit_and_carry_op: e.c = c & t;
      inv_bit_and_carry_op: e.c = c & ~t;
      bit_or_carry_op: e.c = c | t;
      inv_bit_or_carry_op: e.c = c | ~t;
      bit_xor_carry_op: e.c = c ^ t;
      inv_bit_xor_carry_op: e.c = c ^ ~t;
      bit_load_carry_op: e.c = t;
      inv_bit_load_carry_op: e.c = ~t;
      bit_store_carry_op: e.d = c ? a | m : a & ~m;
      inv_bit_store_carry_op: e.d = c ? a & ~m : a | m;
      default: e.d = a;
    endcase
    return e;
  endfunction

  // ----------------------------------------
  // driver
  // ----------------------------------------
  task automatic do_op(input blsb_op_t op, input blsb_byte_t a, src, imm, md,
                       input logic [7:0] f, input logic mem);
    blsb_exp_t  e;
    blsb_idx_t  k;
    logic       bop, mop;
    int         n;
    bop = op >= bit_set_op && mem;
    mop = op <= bit_invert_op || op >= bit_store_carry_op;
    k = (f[4] && op >= bit_set_op && op <= bit_test_op) ? src[2:0] : f[3:1];
    e = model(op, bop ? md : a, f[0] ? imm : src, k, f[5]);
    for (n = 0; n < 20 && busy !== 1'b0; n++) tick();
    op_code = op;
    dest_val = a;
    source_register = src;
    imm_val = imm;
    use_imm = f[0];
    bit_idx_imm = f[3:1];
    idx_from_reg = f[4];
    carry_in = f[5];
    mem_operand = mem;
    exp_q.push_back(bop ? blsb_exp_t'({1'b0, e[11:0]}) : e);
    op_valid = 1'b1;
    tick();
    // held over the busy cycle: that request must be ignored
    if (f[6] && !mem) tick();
    op_valid = 1'b0;
    // idle edge so the next call never raises op_valid in this time step
    if (f[6] && !mem) tick();
    if (bop) begin
      for (n = 0; n < 20 && mem_rd_req !== 1'b1; n++) tick();
      chk(mem_rd_req, 1'b1, "read req");
      mem_rd_valid = 1'b1;
      mem_rd_data = md;
      tick();
      mem_rd_valid = 1'b0;
      mem_rd_data = ~md;
      for (n = 0; n < 4 && mem_wr_req !== 1'b1; n++) tick();
      chk(mem_wr_req, mop, "write req");
      if (mop) begin
        chk(mem_wr_data, e.d, "mem byte");
        mem_wr_ack = 1'b1;
        tick();
        mem_wr_ack = 1'b0;
      end
    end
  endtask

  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(done, 1'b0, "extra done");
      end else begin
        mon_e = exp_q.pop_front();
        chk(reg_wr_en, mon_e.we, "reg we");
        if (mon_e.we) chk(reg_wr_data, mon_e.d, "result");
        chk(carry_we, mon_e.cwe, "carry we");
        if (mon_e.cwe) chk(carry_out, mon_e.c, "carry");
        chk(zero_we, mon_e.zwe, "zero we");
        if (mon_e.zwe) chk(zero_out, mon_e.z, "zero");
      end
    end
  end

  initial begin
    #200000;
    chk(1'b0, 1'b1, "watchdog");
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    blsb_byte_t ra, rs, ri, rm;
    logic [7:0] rf;
    int         i, r, n;
    seed = 32'h6823308E;
    clk = 1'b0;
    rst = 1'b1;
    {op_valid, use_imm, idx_from_reg, carry_in, mem_operand, mem_rd_valid} = 6'h00;
    mem_wr_ack = 1'b0;
    op_code = op_and;
    {dest_val, source_register, imm_val, mem_rd_data} = 32'h0000_0000;
    bit_idx_imm = 3'h0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    for (r = 0; r < 6; r++) begin
      for (i = 0; i < 26; i++) begin
        ra = 8'($random(seed));
        rs = 8'($random(seed));
        ri = 8'($random(seed));
        rm = 8'($random(seed));
        rf = 8'($random(seed));
        do_op(blsb_op_t'(i), ra, rs, ri, rm, rf, 1'b0);
        if (i >= 12) do_op(blsb_op_t'(i), ra, rs, ri, rm, rf, 1'b1);
      end
    end
    do_op(bit_invert_op, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h50, 1'b0);
    do_op(inv_bit_store_carry_op, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h2E, 1'b1);
    // memory flag on a logic op is ignored: plain register result expected
    do_op(op_or, 8'h3C, 8'h0F, 8'h00, 8'hFF, 8'h00, 1'b1);
    for (n = 0; n < 20 && busy !== 1'b0; n++) tick();
    // reset lands in the middle of an operation
    op_code = op_not;
    op_valid = 1'b1;
    tick();
    op_valid = 1'b0;
    rst = 1'b1;
    tick();
    chk(busy, 1'b0, "busy in reset");
    chk(reg_wr_data, 8'h00, "data in reset");
    rst = 1'b0;
    do_op(op_xor, 8'hA5, 8'h0F, 8'h00, 8'h00, 8'h00, 1'b0);
    for (n = 0; n < 20 && exp_q.size() != 0; n++) tick();
    chk(8'(exp_q.size()), 8'h00, "pending results");
    print_verdict();
  end
endmodule  // blsb_tb_top
